// *** dma_request_timer.sv ***
// compare match timer that issues dma transfer requests, with an axi4-lite slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps

module dma_request_timer (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic             dma_req_o,
  output logic             irq_o
);

  logic [15:0] cnt;
  logic [15:0] period;
  logic        run;
  logic        start_rsvd;
  logic        flag;
  logic        csr_rsvd;
  logic [1:0]  csel;
  logic        armed;
  logic        irq_sts;
  logic        irq_msk;
  logic        aw_held;
  logic        w_held;
  logic [5:0]  aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [5:0]  rd_idx;
  logic        tick;
  logic        match_pulse;
  logic        do_write;
  logic        wr_start;
  logic        wr_csr;
  logic        wr_cnt;
  logic        wr_period;
  logic        wr_sts;
  logic        wr_msk;
  logic        wr_hit;
  logic        clr_flag;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic [5:0]  ar_idx;
  logic [15:0] csr_value;
  logic [15:0] start_value;
  logic [31:0] next_rdata;
  logic        rd_hit;

  // merge a 16-bit register with the two low byte lanes of a write
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // ************************************************************
  // prescaler
  // ************************************************************
  clock_divider_tick u_prescaler (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .run_i     (run),
    .sel_i     (csel),
    .tick_o    (tick)
  );

  // ************************************************************
  // write channel: address and data taken in either order
  // ************************************************************
  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o  = !w_held && !bvalid_o;
  assign aw_hs     = awvalid_i && awready_o;
  assign w_hs      = wvalid_i && wready_o;
  assign do_write  = ce_i && aw_held && w_held && !bvalid_o;

  // hold address and data until both are present
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 6'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (ce_i) begin
      if (aw_hs) begin
        aw_held <= 1'b1;
        aw_idx  <= awaddr_i[dma_request_timer_pkg::IDX_HI:dma_request_timer_pkg::IDX_LO];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_hs) begin
        w_held <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode
  assign wr_start  = do_write && (aw_idx == dma_request_timer_pkg::IDX_START);
  assign wr_csr    = do_write && (aw_idx == dma_request_timer_pkg::IDX_CSR);
  assign wr_cnt    = do_write && (aw_idx == dma_request_timer_pkg::IDX_COUNT);
  assign wr_period = do_write && (aw_idx == dma_request_timer_pkg::IDX_PERIOD);
  assign wr_sts    = do_write && (aw_idx == dma_request_timer_pkg::IDX_IRQ_STS);
  assign wr_msk    = do_write && (aw_idx == dma_request_timer_pkg::IDX_IRQ_MSK);
  assign wr_hit    = wr_start || wr_csr || wr_cnt || wr_period || wr_sts || wr_msk;

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= dma_request_timer_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (do_write) begin
        bvalid_o <= 1'b1;
        bresp_o  <= wr_hit ? dma_request_timer_pkg::RESP_OKAY
                           : dma_request_timer_pkg::RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  // start register: run bit and its storage neighbour
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run        <= dma_request_timer_pkg::START_RST[dma_request_timer_pkg::RUN_BIT];
      start_rsvd <= dma_request_timer_pkg::START_RST[dma_request_timer_pkg::START_RSVD_BIT];
    end else if (ce_i && wr_start && w_strb[0]) begin
      run        <= w_data[dma_request_timer_pkg::RUN_BIT];
      start_rsvd <= w_data[dma_request_timer_pkg::START_RSVD_BIT];
    end
  end

  // control/status writable fields; only reset reinitialises them
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      csel     <= dma_request_timer_pkg::CSEL_RST;
      csr_rsvd <= dma_request_timer_pkg::CSR_RST[dma_request_timer_pkg::CSR_RSVD_BIT];
    end else if (ce_i && wr_csr && w_strb[0]) begin
      csel     <= w_data[dma_request_timer_pkg::CSEL_HI:dma_request_timer_pkg::CSEL_LO];
      csr_rsvd <= w_data[dma_request_timer_pkg::CSR_RSVD_BIT];
    end
  end

  // period constant
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      period <= dma_request_timer_pkg::PERIOD_RST;
    end else if (ce_i && wr_period) begin
      period <= merge16(period, w_data, w_strb);
    end
  end

  // ************************************************************
  // counter and compare match
  // ************************************************************
  // a software write to the counter takes precedence over a tick
  assign match_pulse = ce_i && tick && run && !wr_cnt && (cnt == period);

  // up-counter; holds while halted
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= dma_request_timer_pkg::COUNT_RST;
    end else if (ce_i) begin
      if (wr_cnt) begin
        cnt <= merge16(cnt, w_data, w_strb);
      end else if (tick && run) begin
        if (cnt == period) begin
          cnt <= 16'h0000;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end

  // transfer request pulse toward the dma controller
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dma_req_o <= 1'b0;
    end else if (ce_i) begin
      dma_req_o <= match_pulse;
    end
  end

  // ************************************************************
  // match flag with read-then-clear protocol
  // ************************************************************
  assign clr_flag = wr_csr && w_strb[0] && !w_data[dma_request_timer_pkg::FLAG_BIT] && armed;

  // armed once software has seen the flag at one; any control/status write disarms
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      armed <= 1'b0;
    end else if (ce_i) begin
      if (wr_csr) begin
        armed <= 1'b0;
      end else if (ar_hs && (ar_idx == dma_request_timer_pkg::IDX_CSR) && flag) begin
        armed <= 1'b1;
      end
    end
  end

  // a match in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag <= dma_request_timer_pkg::CSR_RST[dma_request_timer_pkg::FLAG_BIT];
    end else if (ce_i) begin
      if (match_pulse) begin
        flag <= 1'b1;
      end else if (clr_flag) begin
        flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // interrupt status and mask
  // ************************************************************
  // sticky status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_sts <= 1'b0;
      irq_msk <= 1'b0;
    end else if (ce_i) begin
      if (match_pulse) begin
        irq_sts <= 1'b1;
      end else if (wr_sts && w_strb[0] && w_data[dma_request_timer_pkg::IRQ_MATCH_BIT]) begin
        irq_sts <= 1'b0;
      end
      if (wr_msk && w_strb[0]) begin
        irq_msk <= w_data[dma_request_timer_pkg::IRQ_MATCH_BIT];
      end
    end
  end

  assign irq_o = irq_sts && irq_msk;

  // ************************************************************
  // read channel
  // ************************************************************
  assign arready_o = !rvalid_o;
  assign ar_hs     = ce_i && arvalid_i && arready_o;
  assign ar_idx    = araddr_i[dma_request_timer_pkg::IDX_HI:dma_request_timer_pkg::IDX_LO];

  // read views; unlisted bits stay zero
  always_comb begin
    csr_value   = 16'h0000;
    start_value = 16'h0000;
    csr_value[dma_request_timer_pkg::FLAG_BIT]     = flag;
    csr_value[dma_request_timer_pkg::CSR_RSVD_BIT] = csr_rsvd;
    csr_value[dma_request_timer_pkg::CSEL_HI:dma_request_timer_pkg::CSEL_LO] = csel;
    start_value[dma_request_timer_pkg::RUN_BIT]        = run;
    start_value[dma_request_timer_pkg::START_RSVD_BIT] = start_rsvd;
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    case (ar_idx)
      dma_request_timer_pkg::IDX_START:   next_rdata[15:0] = start_value;
      dma_request_timer_pkg::IDX_CSR:     next_rdata[15:0] = csr_value;
      dma_request_timer_pkg::IDX_COUNT:   next_rdata[15:0] = cnt;
      dma_request_timer_pkg::IDX_PERIOD:  next_rdata[15:0] = period;
      dma_request_timer_pkg::IDX_IRQ_STS: next_rdata[0]    = irq_sts;
      dma_request_timer_pkg::IDX_IRQ_MSK: next_rdata[0]    = irq_msk;
      default:                            rd_hit           = 1'b0;
    endcase
  end

  // registered read data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0000_0000;
      rresp_o  <= dma_request_timer_pkg::RESP_OKAY;
      rd_idx   <= 6'h00;
    end else if (ce_i) begin
      if (ar_hs) begin
        rvalid_o <= 1'b1;
        rdata_o  <= next_rdata;
        rd_idx   <= ar_idx;
        rresp_o  <= rd_hit ? dma_request_timer_pkg::RESP_OKAY
                           : dma_request_timer_pkg::RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_match_edge;
    ce_i && tick && run && !wr_cnt && (cnt == period);
  endsequence

  sequence s_after_match;
    (cnt == 16'h0000) && flag && dma_req_o;
  endsequence

  a_match_clears_count: assert property (s_match_edge |=> s_after_match)
    else $error("match did not clear counter and set flag and request");

  a_count_steps_up: assert property (ce_i && tick && run && !wr_cnt && (cnt != period)
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not step by one on a tick");

  a_halt_holds_count: assert property (ce_i && !run && !wr_cnt |=> $stable(cnt))
    else $error("counter moved while halted");

  a_no_early_match: assert property ($rose(dma_req_o) |-> $past(tick) && $past(cnt == period))
    else $error("transfer request without a tick at equality");

  a_request_single: assert property (dma_req_o && !$past(tick) |-> 1'b0)
    else $error("transfer request not caused by a tick");

  a_flag_clear_guard: assert property ($fell(flag) |-> $past(armed) && $past(wr_csr))
    else $error("match flag cleared without read then zero write");

  a_flag_one_write: assert property (wr_csr && w_strb[0] && w_data[7] && flag |=> flag)
    else $error("writing one changed the match flag");

  a_csr_reserved_zero: assert property (rvalid_o && (rd_idx == dma_request_timer_pkg::IDX_CSR)
    |-> (rdata_o[15:8] == 8'h00) && (rdata_o[5:2] == 4'h0))
    else $error("reserved control bits read nonzero");

  a_reset_values: assert property ($past(sys_rst_i) |-> (period == 16'hffff)
    && (cnt == 16'h0000) && !flag && (csel == 2'h0) && !run)
    else $error("register reset values wrong");

  a_irq_follows_mask: assert property (match_pulse && irq_msk && !wr_msk |=> irq_o)
    else $error("unmasked match did not raise interrupt");

endmodule

// *** dma_request_timer_pkg.sv ***
// constants shared by the dma request compare timer files
package dma_request_timer_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 7;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_START   = 6'h00;
  localparam logic [5:0] IDX_CSR     = 6'h02;
  localparam logic [5:0] IDX_COUNT   = 6'h04;
  localparam logic [5:0] IDX_PERIOD  = 6'h06;
  localparam logic [5:0] IDX_IRQ_STS = 6'h08;
  localparam logic [5:0] IDX_IRQ_MSK = 6'h09;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int RUN_BIT        = 0;
  localparam int START_RSVD_BIT = 1;
  localparam int CSEL_LO        = 0;
  localparam int CSEL_HI        = 1;
  localparam int CSR_RSVD_BIT   = 6;
  localparam int FLAG_BIT       = 7;
  localparam int IRQ_MATCH_BIT  = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] START_RST  = 16'h0000;
  localparam logic [15:0] CSR_RST    = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [1:0]  CSEL_RST   = 2'h0;

  // ************************************************************
  // clock select codes and last prescaler count of each
  // ************************************************************
  localparam logic [1:0] CSEL_DIV4  = 2'h0;
  localparam logic [1:0] CSEL_DIV8  = 2'h1;
  localparam logic [1:0] CSEL_DIV16 = 2'h2;
  localparam logic [1:0] CSEL_DIV64 = 2'h3;
  localparam logic [5:0] LAST_DIV4  = 6'h03;
  localparam logic [5:0] LAST_DIV8  = 6'h07;
  localparam logic [5:0] LAST_DIV16 = 6'h0f;
  localparam logic [5:0] LAST_DIV64 = 6'h3f;

  // ************************************************************
  // bus responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** clock_divider_tick.sv ***
// prescaler that gives one tick per selected division of the peripheral clock
`timescale 1ns/10ps

module clock_divider_tick (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  logic [5:0] pre;
  logic [5:0] last;

  // ************************************************************
  // terminal count for the selected division
  // ************************************************************
  always_comb begin
    case (sel_i)
      dma_request_timer_pkg::CSEL_DIV4:  last = dma_request_timer_pkg::LAST_DIV4;
      dma_request_timer_pkg::CSEL_DIV8:  last = dma_request_timer_pkg::LAST_DIV8;
      dma_request_timer_pkg::CSEL_DIV16: last = dma_request_timer_pkg::LAST_DIV16;
      default:                           last = dma_request_timer_pkg::LAST_DIV64;
    endcase
  end

  // ************************************************************
  // divider counter; held at zero while halted
  // ************************************************************
  // wraps on >= so a smaller division picked mid-count does not run to 63
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre    <= 6'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        pre    <= 6'h00;
        tick_o <= 1'b0;
      end else if (pre >= last) begin
        pre    <= 6'h00;
        tick_o <= 1'b1;
      end else begin
        pre    <= pre + 6'h01;
        tick_o <= 1'b0;
      end
    end
  end

endmodule

// *** dma_req_sink.sv ***
// dma controller request input model that counts one-cycle transfer requests
`timescale 1ns/10ps

module dma_req_sink (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        req_i,
  output logic [15:0]      pulse_cnt_o,
  output logic             wide_o
);
  logic prev;

  // count requests and flag any request held past one cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pulse_cnt_o <= 16'h0000;
      wide_o      <= 1'b0;
      prev        <= 1'b0;
    end else begin
      prev <= req_i;
      if (req_i && !prev) begin
        pulse_cnt_o <= pulse_cnt_o + 16'h0001;
      end
      if (req_i && prev) begin
        wide_o <= 1'b1;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// self-checking testbench for the dma request compare timer
`timescale 1ns/10ps

module tb_top;
  // ************************************************************
  // signals and addresses
  // ************************************************************
  localparam logic [7:0] A_START  = {dma_request_timer_pkg::IDX_START, 2'b00};
  localparam logic [7:0] A_CSR    = {dma_request_timer_pkg::IDX_CSR, 2'b00};
  localparam logic [7:0] A_COUNT  = {dma_request_timer_pkg::IDX_COUNT, 2'b00};
  localparam logic [7:0] A_PERIOD = {dma_request_timer_pkg::IDX_PERIOD, 2'b00};
  localparam logic [7:0] A_STS    = {dma_request_timer_pkg::IDX_IRQ_STS, 2'b00};
  localparam logic [7:0] A_MSK    = {dma_request_timer_pkg::IDX_IRQ_MSK, 2'b00};
  localparam logic [7:0] A_BAD    = 8'h40;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b1; // answers are always accepted
  logic        arvalid = 1'b0;
  logic        rready = 1'b1; // answers are always accepted
  logic        ce = 1'b1;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, dma_req_o, irq_o, wide;
  logic [1:0]  bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic [15:0] pulses;
  int          errors = 0;
  int          comparisons = 0;

  always #5 clk_i = ~clk_i;

  dma_request_timer i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready_o),
    .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready),
    .dma_req_o(dma_req_o), .irq_o(irq_o)
  );

  dma_req_sink i_sink (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(dma_req_o),
    .pulse_cnt_o(pulses), .wide_o(wide)
  );

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // divide ratio of each clock select code
  function automatic int div_of(input int c);
    return (c == 0) ? 4 : (c == 1) ? 8 : (c == 2) ? 16 : 64;
  endfunction

  // match latency window around t cycles, allowing for bus overhead
  function automatic logic [31:0] win_ok(input int n, input int t);
    return {31'h0, (n >= t - 4) && (n <= t + 3)};
  endfunction

  // ************************************************************
  // bus master tasks, entered just after a rising edge
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic at, wt, aok, wok, bok;
    at = 1'b0;
    wt = 1'b0;
    bok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(at && wt)) begin
      @(negedge clk_i);
      aok = awvalid && awready_o;
      wok = wvalid && wready_o;
      @(posedge clk_i);
      if (aok) begin
        awvalid <= 1'b0;
        at = 1'b1;
      end
      if (wok) begin
        wvalid <= 1'b0;
        wt = 1'b1;
      end
    end
    while (!bok) begin
      @(negedge clk_i);
      bok = bvalid_o;
      r = bresp_o;
      @(posedge clk_i);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aok, rok;
    aok = 1'b0;
    rok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!aok) begin
      @(negedge clk_i);
      aok = arready_o;
      @(posedge clk_i);
    end
    arvalid <= 1'b0;
    while (!rok) begin
      @(negedge clk_i);
      rok = rvalid_o;
      d = rdata_o;
      r = rresp_o;
      @(posedge clk_i);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [1:0]  r;
    logic [31:0] d, v;
    logic [15:0] p;
    logic [15:0] base;
    int          n;
    void'($urandom(69155));
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values
    rd(A_START, d, r); chk(d, 32'h0000_0000);
    rd(A_CSR, d, r); chk(d, 32'h0000_0000);
    rd(A_COUNT, d, r); chk(d, 32'h0000_0000);
    rd(A_PERIOD, d, r); chk(d, 32'h0000_ffff);
    chk({30'h0, r}, 32'h0000_0000);
    // reserved and storage bits, flag not set by a one write
    wr(A_CSR, 32'hffff_ffff, 4'hf, r);
    chk({30'h0, r}, 32'h0000_0000);
    rd(A_CSR, d, r); chk(d, 32'h0000_0043);
    wr(A_CSR, 32'h0000_0000, 4'hf, r);
    wr(A_START, 32'h0000_0002, 4'hf, r);
    rd(A_START, d, r); chk(d, 32'h0000_0002);
    // unmapped place
    wr(A_BAD, 32'h0000_1234, 4'hf, r); chk({30'h0, r}, 32'h0000_0002);
    rd(A_BAD, d, r); chk({d[31:2], r}, 32'h0000_0002);
    // random counter and period readback, lane strobes
    repeat (4) begin
      v = $urandom;
      wr(A_COUNT, v, 4'hf, r);
      rd(A_COUNT, d, r); chk(d, {16'h0000, v[15:0]});
      v = $urandom;
      wr(A_PERIOD, v, 4'hf, r);
      wr(A_PERIOD, 32'h0000_00a5, 4'h1, r);
      rd(A_PERIOD, d, r); chk(d, {16'h0000, v[15:8], 8'ha5});
    end
    // one compare match under each clock select
    for (int c = 0; c < 4; c++) begin
      p = 16'(1 + $urandom_range(2));
      wr(A_CSR, 32'(c), 4'h1, r);
      wr(A_PERIOD, {16'h0000, p}, 4'hf, r);
      wr(A_COUNT, 32'h0000_0000, 4'hf, r);
      wr(A_MSK, 32'(c & 1), 4'hf, r);
      base = pulses;
      wr(A_START, 32'h0000_0001, 4'hf, r);
      n = 0;
      while (pulses == base) begin
        @(posedge clk_i);
        n++;
      end
      chk(win_ok(n, (int'(p) + 1) * div_of(c)), 32'h0000_0001);
      chk({31'h0, irq_o}, 32'(c & 1));
      wr(A_START, 32'h0000_0000, 4'hf, r);
      rd(A_COUNT, d, r);
      repeat (100) @(posedge clk_i);
      rd(A_COUNT, v, r); chk(v, d);
      rd(A_CSR, d, r); chk(d, 32'h0000_0080 | 32'(c));
      wr(A_CSR, 32'h0000_0080 | 32'(c), 4'h1, r);
      rd(A_CSR, d, r); chk(d, 32'h0000_0080 | 32'(c));
      wr(A_CSR, 32'(c), 4'h1, r);
      rd(A_CSR, d, r); chk(d, 32'(c));
      rd(A_STS, d, r); chk(d, 32'h0000_0001);
      wr(A_STS, 32'h0000_0001, 4'hf, r);
      rd(A_STS, d, r); chk(d, 32'h0000_0000);
      chk({31'h0, irq_o}, 32'h0000_0000);
    end
    // clock enable low freezes a running counter
    wr(A_PERIOD, 32'h0000_fff0, 4'hf, r);
    wr(A_CSR, 32'h0000_0000, 4'h1, r);
    wr(A_COUNT, 32'h0000_0000, 4'hf, r);
    wr(A_START, 32'h0000_0001, 4'hf, r);
    repeat (20) @(posedge clk_i);
    rd(A_COUNT, d, r);
    ce <= 1'b0;
    repeat (400) @(posedge clk_i);
    ce <= 1'b1;
    rd(A_COUNT, v, r);
    chk({31'h0, (v - d) <= 32'h0000_0001}, 32'h0000_0001);
    chk({16'h0000, pulses}, 32'h0000_0004);
    chk({31'h0, wide}, 32'h0000_0000);
    // reset in mid-run puts the count, period and start registers back to their reset values
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_COUNT, d, r); chk(d, 32'h0000_0000);
    rd(A_PERIOD, d, r); chk(d, 32'h0000_ffff);
    rd(A_START, d, r); chk(d, 32'h0000_0000);
    complete_run();
  end

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    complete_run();
  end
endmodule
